// ---- hdl/its_pkg.sv ----
// Package for the ignition timing schedule block: constants and carriers
package its_pkg;
  localparam int TW              = 16;   // Signed timing, 0.1 deg units, advance positive
  localparam int AW              = 12;   // Analog sample width
  localparam int SW              = 16;   // Engine speed width, rpm
  localparam int NCYL            = 8;
  localparam int MAX_PTS         = 8;
  localparam int PTS_W           = 4;
  localparam logic [SW-1:0] FIRST_PT_SPEED = 16'h0000;
  localparam logic [TW-1:0] RST_TIMING     = 16'h0000;
  localparam int CALC_LAT        = 2;    // Clocks from sample to registered result

  // Analog adjustment settings of one input within one schedule
  typedef struct packed {
    logic          en;
    logic          fail_def;   // A failure threshold is defined
    logic [AW-1:0] lo_lim;
    logic [AW-1:0] hi_lim;
    logic [AW-1:0] fail_thr;
    logic [TW-1:0] at_lo;
    logic [TW-1:0] at_hi;
    logic [TW-1:0] dflt;
  } its_ana_t;

  // One schedule's full configuration
  typedef struct packed {
    logic                      en;
    logic [TW-1:0]             t_min;
    logic [TW-1:0]             t_max;
    logic [TW-1:0]             base;
    logic [TW-1:0]             ind_adv;
    logic [TW-1:0]             ind_ret;
    its_ana_t                  cur;
    its_ana_t                  vlt;
    logic                      crv_en;
    logic [PTS_W-1:0]          crv_n;
    logic [MAX_PTS-1:0][SW-1:0] crv_spd;
    logic [MAX_PTS-1:0][TW-1:0] crv_ofs;
  } its_sched_t;
endpackage

// ---- hdl/its_timing.sv ----
// Global ignition timing and per-cylinder offset clamp from two schedules
`timescale 1ns/10ps
module its_timing
  import its_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire its_pkg::its_sched_t   cfg_a,
  input  wire its_pkg::its_sched_t   cfg_b,
  input  wire logic                  sched_sel_pin,
  input  wire logic [its_pkg::AW-1:0] cur_sample,
  input  wire logic [its_pkg::AW-1:0] vlt_sample,
  input  wire logic [its_pkg::SW-1:0] engine_speed,
  input  wire logic [its_pkg::NCYL-1:0][its_pkg::TW-1:0] cyl_ofs_req,
  output logic                       sched_b_active,
  output logic                       cur_failed,
  output logic                       vlt_failed,
  output logic [its_pkg::TW-1:0]     global_timing,
  output logic [its_pkg::NCYL-1:0][its_pkg::TW-1:0] cyl_timing
);
  import its_pkg::*;

  logic sel_meta;
  logic sel_sync;
  its_sched_t cfg;
  logic cur_fail_q;
  logic vlt_fail_q;
  logic signed [TW+1:0] sum_q;
  logic signed [TW-1:0] glob_q;

  function automatic logic signed [TW-1:0] clamp(input logic signed [TW+1:0] v,
                                                  input logic signed [TW-1:0] lo,
                                                  input logic signed [TW-1:0] hi);
    if (v < lo) clamp = lo;
    else if (v > hi) clamp = hi;
    else clamp = v[TW-1:0];
  endfunction

  // Linear interpolation, x clipped to [x0,x1]; degenerate span gives y0
  function automatic logic signed [TW-1:0] lerp(input logic [SW-1:0] x,
                                                 input logic [SW-1:0] x0,
                                                 input logic [SW-1:0] x1,
                                                 input logic signed [TW-1:0] y0,
                                                 input logic signed [TW-1:0] y1);
    logic signed [TW+SW+1:0] num;
    logic [SW-1:0] dx;
    num = '0;
    dx = '0;
    if (x1 <= x0 || x <= x0) lerp = y0;
    else if (x >= x1) lerp = y1;
    else begin
      dx = x - x0;
      num = (TW+SW+2)'((y1 - y0) * $signed({1'b0, dx}));
      lerp = TW'(y0 + num / $signed({1'b0, x1 - x0}));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Select pin comes from outside: two-flop synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else begin
      sel_meta <= sched_sel_pin;
      sel_sync <= sel_meta;
    end
  end

  // Both disabled is not allowed by software; fall back to the first schedule
  logic use_b;
  always_comb begin
    if (cfg_a.en && !cfg_b.en) use_b = 1'b0;
    else if (!cfg_a.en && cfg_b.en) use_b = 1'b1;
    else if (!cfg_a.en && !cfg_b.en) use_b = 1'b0;
    else use_b = sel_sync;
    cfg = use_b ? cfg_b : cfg_a;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) sched_b_active <= 1'b0;
    else sched_b_active <= use_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches with hysteresis: enter below threshold, leave above lower limit
  logic next_cur_fail;
  logic next_vlt_fail;
  always_comb begin
    next_cur_fail = cur_fail_q;
    if (!cfg.cur.en || !cfg.cur.fail_def) next_cur_fail = 1'b0;
    else if (cur_sample < cfg.cur.fail_thr) next_cur_fail = 1'b1;
    else if (cur_sample > cfg.cur.lo_lim) next_cur_fail = 1'b0;
    next_vlt_fail = vlt_fail_q;
    if (!cfg.vlt.en || !cfg.vlt.fail_def) next_vlt_fail = 1'b0;
    else if (vlt_sample < cfg.vlt.fail_thr) next_vlt_fail = 1'b1;
    else if (vlt_sample > cfg.vlt.lo_lim) next_vlt_fail = 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_fail_q <= 1'b0;
      vlt_fail_q <= 1'b0;
    end else begin
      cur_fail_q <= next_cur_fail;
      vlt_fail_q <= next_vlt_fail;
    end
  end
  assign cur_failed = cur_fail_q;
  assign vlt_failed = vlt_fail_q;

  ////////////////////////////////////////////////////////////////////////////
  // Offset terms
  logic signed [TW-1:0] cur_ofs;
  logic signed [TW-1:0] vlt_ofs;
  logic signed [TW-1:0] crv_ofs;
  always_comb begin
    cur_ofs = '0;
    vlt_ofs = '0;
    if (cfg.cur.en) begin
      if (next_cur_fail) cur_ofs = cfg.cur.dflt;
      else cur_ofs = lerp(SW'(cur_sample), SW'(cfg.cur.lo_lim), SW'(cfg.cur.hi_lim),
                          cfg.cur.at_lo, cfg.cur.at_hi);
    end
    if (cfg.vlt.en) begin
      if (next_vlt_fail) vlt_ofs = cfg.vlt.dflt;
      else vlt_ofs = lerp(SW'(vlt_sample), SW'(cfg.vlt.lo_lim), SW'(cfg.vlt.hi_lim),
                          cfg.vlt.at_lo, cfg.vlt.at_hi);
    end
  end

  // Curve: point 0 pinned at zero rpm; ascending order is relied on
  logic [MAX_PTS-1:0][SW-1:0] spd;
  logic [PTS_W-1:0] npts;
  always_comb begin
    spd = cfg.crv_spd;
    spd[0] = FIRST_PT_SPEED;
    npts = (cfg.crv_n > PTS_W'(MAX_PTS)) ? PTS_W'(MAX_PTS) : cfg.crv_n;
    crv_ofs = '0;
    if (cfg.crv_en && npts != '0) begin
      crv_ofs = cfg.crv_ofs[0];
      for (int i = 1; i < MAX_PTS; i++) begin
        if (PTS_W'(i) < npts && engine_speed >= spd[i-1]) begin
          crv_ofs = lerp(engine_speed, spd[i-1], spd[i],
                         cfg.crv_ofs[i-1], cfg.crv_ofs[i]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage pipeline: sum, then clamp
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) sum_q <= '0;
    else sum_q <= (TW+2)'($signed(cfg.base)) + (TW+2)'(cur_ofs)
                  + (TW+2)'(vlt_ofs) + (TW+2)'(crv_ofs);
  end

  logic signed [TW-1:0] lim_lo_q;
  logic signed [TW-1:0] lim_hi_q;
  logic signed [TW-1:0] adv_q;
  logic signed [TW-1:0] ret_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lim_lo_q <= '0;
      lim_hi_q <= '0;
      adv_q <= '0;
      ret_q <= '0;
    end else begin
      lim_lo_q <= cfg.t_min;
      lim_hi_q <= cfg.t_max;
      adv_q <= cfg.ind_adv;
      ret_q <= cfg.ind_ret;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) glob_q <= RST_TIMING;
    else glob_q <= clamp(sum_q, lim_lo_q, lim_hi_q);
  end
  assign global_timing = glob_q;

  // Per cylinder: individual offset clamped, then firing point clamped again
  for (genvar c = 0; c < NCYL; c++) begin : g_cyl
    logic signed [TW-1:0] ind;
    logic signed [TW-1:0] fire_q;
    assign ind = clamp((TW+2)'($signed(cyl_ofs_req[c])), -ret_q, adv_q);
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) fire_q <= RST_TIMING;
      else fire_q <= clamp((TW+2)'(glob_q) + (TW+2)'(ind),
                           lim_lo_q, lim_hi_q);
    end
    // Own flop per cylinder: one process never shares a packed output with another
    assign cyl_timing[c] = fire_q;

    AST_CYL_LIM: assert property (@(posedge core_clk) disable iff (rst)
      ##1 ($signed(cyl_timing[c]) >= $past(lim_lo_q) || $past(lim_lo_q) > $past(lim_hi_q))
      && ($signed(cyl_timing[c]) <= $past(lim_hi_q) || $past(lim_lo_q) > $past(lim_hi_q)))
      else $error("cylinder timing outside limits");
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_ONLY_A: assert property (@(posedge core_clk) disable iff (rst)
    (cfg_a.en && !cfg_b.en) |=> !sched_b_active)
    else $error("enabled schedule A not used");
  AST_ONLY_B: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg_a.en && cfg_b.en) |=> sched_b_active)
    else $error("enabled schedule B not used");
  AST_SEL: assert property (@(posedge core_clk) disable iff (rst)
    (cfg_a.en && cfg_b.en) |=> sched_b_active == $past(sel_sync))
    else $error("select pin not followed");
  AST_GLOB_LIM: assert property (@(posedge core_clk) disable iff (rst)
    (lim_lo_q <= lim_hi_q) |=> ($signed(glob_q) >= $past(lim_lo_q))
                                && ($signed(glob_q) <= $past(lim_hi_q)))
    else $error("global timing outside limits");
  AST_FAIL_SET: assert property (@(posedge core_clk) disable iff (rst)
    (cfg.cur.en && cfg.cur.fail_def && cur_sample < cfg.cur.fail_thr) |=> cur_failed)
    else $error("current fault not flagged");
  AST_FAIL_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    (cur_failed && cfg.cur.en && cfg.cur.fail_def && cur_sample <= cfg.cur.lo_lim)
    |=> cur_failed)
    else $error("current fault released early");
  AST_DFLT: assert property (@(posedge core_clk) disable iff (rst)
    (cfg.cur.en && next_cur_fail) |-> cur_ofs == $signed(cfg.cur.dflt))
    else $error("failure default not applied");
  AST_VFAIL: assert property (@(posedge core_clk) disable iff (rst)
    (!cfg.vlt.en) |=> !vlt_failed)
    else $error("disabled voltage input flagged failed");
  AST_CRV_OFF: assert property (@(posedge core_clk) disable iff (rst)
    !cfg.crv_en |-> crv_ofs == '0)
    else $error("curve offset while disabled");
  AST_CYL_IND: assert property (@(posedge core_clk) disable iff (rst)
    (adv_q >= 0 && ret_q >= 0) |-> g_cyl[0].ind <= adv_q && g_cyl[0].ind >= -ret_q)
    else $error("individual offset not clamped");

  COV_SWAP: cover property (@(posedge core_clk) disable iff (rst)
    !sched_b_active ##1 sched_b_active);
  COV_CUR_FAIL: cover property (@(posedge core_clk) disable iff (rst)
    cur_failed ##1 !cur_failed);
  COV_CLAMP: cover property (@(posedge core_clk) disable iff (rst)
    sum_q > lim_hi_q);
  COV_CURVE: cover property (@(posedge core_clk) disable iff (rst)
    cfg.crv_en && crv_ofs != '0);
endmodule

// ---- sim/its_sensor_model.sv ----
// Engine speed pickup and analog adjustment source model
`timescale 1ns/10ps
module its_sensor_model
  import its_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic [its_pkg::SW-1:0] speed_set,
  input  wire logic [its_pkg::AW-1:0] cur_set,
  input  wire logic [its_pkg::AW-1:0] vlt_set,
  output logic      [its_pkg::SW-1:0] engine_speed,
  output logic      [its_pkg::AW-1:0] cur_sample,
  output logic      [its_pkg::AW-1:0] vlt_sample
);
  // Converters refresh on the core edge, so each new sample lands one clock late
  always_ff @(posedge core_clk) begin
    engine_speed <= speed_set;
    cur_sample   <= cur_set;
    vlt_sample   <= vlt_set;
  end
endmodule

// ---- sim/tb.sv ----
// Testbench for the ignition timing schedule block
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  import its_pkg::*;
  logic                    core_clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    sched_sel_pin = 1'b0;
  its_sched_t              cfg_a = '0;
  its_sched_t              cfg_b = '0;
  logic [SW-1:0]           speed_set = 16'h0000;
  logic [AW-1:0]           cur_set = 12'h100;
  logic [AW-1:0]           vlt_set = 12'h500;
  logic [SW-1:0]           engine_speed;
  logic [AW-1:0]           cur_sample;
  logic [AW-1:0]           vlt_sample;
  logic [NCYL-1:0][TW-1:0] cyl_ofs_req = '0;
  logic                    sched_b_active;
  logic                    cur_failed;
  logic                    vlt_failed;
  logic [TW-1:0]           global_timing;
  logic [NCYL-1:0][TW-1:0] cyl_timing;
  int                      n_mismatch = 0;
  int                      cmp_count = 0;
  int                      seed = 38579;
  bit                      fc;
  bit                      fv;
  int                      sp[6] = '{0, 250, 500, 850, 1200, 3000};
  always #20 core_clk = ~core_clk;
  its_sensor_model PM (.core_clk(core_clk), .speed_set(speed_set), .cur_set(cur_set),
    .vlt_set(vlt_set), .engine_speed(engine_speed), .cur_sample(cur_sample),
    .vlt_sample(vlt_sample));
  its_timing DUT (.core_clk(core_clk), .rst(rst), .cfg_a(cfg_a), .cfg_b(cfg_b),
    .sched_sel_pin(sched_sel_pin), .cur_sample(cur_sample), .vlt_sample(vlt_sample),
    .engine_speed(engine_speed), .cyl_ofs_req(cyl_ofs_req), .sched_b_active(sched_b_active),
    .cur_failed(cur_failed), .vlt_failed(vlt_failed), .global_timing(global_timing),
    .cyl_timing(cyl_timing));
  function automatic int sx(logic [TW-1:0] v);
    return int'($signed(v));
  endfunction
  function automatic int lerp(int x, int x0, int x1, int y0, int y1);
    if (x <= x0) return y0;
    if (x >= x1) return y1;
    return y0 + (y1 - y0) * (x - x0) / (x1 - x0);
  endfunction
  function automatic int clip(int v, int lo, int hi);
    return (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction
  function automatic int ana(its_ana_t a, int s, inout bit f);
    if (!a.en) f = 0;
    else if (!a.fail_def) f = 0;
    else if (s < a.fail_thr) f = 1;
    else if (s > a.lo_lim) f = 0;
    if (!a.en) return 0;
    return f ? sx(a.dflt) : lerp(s, a.lo_lim, a.hi_lim, sx(a.at_lo), sx(a.at_hi));
  endfunction
  task automatic step(string name);
    its_sched_t c;
    bit ub;
    int g, n, cv, i, o;
    for (i = 0; i < NCYL; i++) cyl_ofs_req[i] = TW'($random(seed) % 80);
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    ub = cfg_b.en && (!cfg_a.en || sched_sel_pin);
    c = ub ? cfg_b : cfg_a;
    `CHK(sched_b_active, ub)
    g = sx(c.base) + ana(c.cur, cur_sample, fc) + ana(c.vlt, vlt_sample, fv);
    `CHK(cur_failed, fc)
    `CHK(vlt_failed, fv)
    n = (c.crv_n > 8) ? 8 : c.crv_n;
    cv = 0;
    if (c.crv_en && n > 0) begin
      cv = sx(c.crv_ofs[n-1]);
      for (i = n - 1; i >= 1; i--)
        if (engine_speed < c.crv_spd[i])
          cv = lerp(engine_speed, (i == 1) ? 0 : c.crv_spd[i-1], c.crv_spd[i],
                    sx(c.crv_ofs[i-1]), sx(c.crv_ofs[i]));
    end
    g = clip(g + cv, sx(c.t_min), sx(c.t_max));
    `CHK(global_timing, TW'(g))
    for (i = 0; i < NCYL; i++) begin
      o = clip(sx(cyl_ofs_req[i]), -sx(c.ind_ret), sx(c.ind_adv));
      `CHK(cyl_timing[i], TW'(clip(g + o, sx(c.t_min), sx(c.t_max))))
    end
    $display("test %s done", name);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 2000);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    cfg_a.en = 1'b1;
    cfg_a.t_min = 16'hFF38;
    cfg_a.t_max = 16'h012C;
    cfg_a.base = 16'h00A0;
    cfg_a.ind_adv = 16'h0032;
    cfg_a.ind_ret = 16'h0032;
    cfg_a.cur = '{1'b1, 1'b1, 12'h100, 12'h500, 12'h080, 16'h0032, 16'hFFCE, 16'h0014};
    cfg_b = cfg_a;
    cfg_b.base = 16'h0064;
    cfg_b.cur.en = 1'b0;
    repeat (20) @(negedge core_clk);
    `CHK(global_timing, RST_TIMING)
    rst = 1'b0;
    step("select_a");
    sched_sel_pin = 1'b1;
    step("select_b");
    cfg_a.en = 1'b0;
    sched_sel_pin = 1'b0;
    step("only_b");
    cfg_a.en = 1'b1;
    cfg_b.en = 1'b0;
    sched_sel_pin = 1'b1;
    step("only_a");
    cfg_a.vlt = cfg_a.cur;
    cfg_a.vlt.fail_def = 1'b0;
    foreach (sp[i]) begin
      cur_set = AW'(sp[i] * 4 + 12'h100);
      step("analog_sweep");
    end
    cur_set = 12'h040;
    step("fault_enter");
    cur_set = 12'h0C0;
    step("fault_hold");
    cur_set = 12'h300;
    step("fault_clear");
    cur_set = 12'h0C0;
    step("band_healthy");
    cfg_a.base = 16'h012C;
    cur_set = 12'h100;
    vlt_set = 12'h100;
    step("clamp_high");
    cfg_a.base = 16'hFF38;
    cur_set = 12'h500;
    vlt_set = 12'h500;
    step("clamp_low");
    cfg_a.base = 16'h00A0;
    cfg_a.vlt.fail_def = 1'b1;
    vlt_set = 12'h040;
    step("vlt_fault");
    vlt_set = 12'h500;
    step("vlt_recover");
    cfg_a.crv_en = 1'b1;
    cfg_a.crv_n = 4'h3;
    cfg_a.crv_spd[2:0] = {16'h04B0, 16'h01F4, 16'h0000};
    cfg_a.crv_ofs[2:0] = {16'hFFEC, 16'hFFF6, 16'hFFCE};
    foreach (sp[i]) begin
      speed_set = SW'(sp[i]);
      step("speed_curve");
    end
    cfg_a.crv_n = 4'h1;
    step("curve_one_point");
    cfg_a.crv_n = 4'hF;
    cfg_a.crv_spd[7:3] = {16'h0FA0, 16'h0DAC, 16'h0BB8, 16'h09C4, 16'h07D0};
    cfg_a.crv_ofs[7:3] = {16'h0014, 16'h000A, 16'h0005, 16'hFFFB, 16'hFFF6};
    speed_set = 16'h0A00;
    step("curve_eight_mid");
    speed_set = 16'h1388;
    step("curve_past_last");
    tally_and_finish();
  end
endmodule
